// ===== hw/cdu_top.sv
// Purpose: control logic of a 10-bit current-output dac with staged update
// Assumes: axi4-lite slave on sys_clk; strobe pin asynchronous
// Notes:
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module cdu_top
    import cdu_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // axi4-lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // update event sources
    input  wire logic [3:0]  timer_overflow,
    input  wire logic        external_convert_strobe,
    // pin control
    input  wire logic        gpio_out,
    input  wire logic        gpio_oe,
    input  wire logic        gpio_pullup_en,
    output logic             pin_out,
    output logic             pin_oe,
    output logic             pin_pullup_on,
    output logic             pin_analog_connect,
    // converter analogue side
    output logic [9:0]       dac_latch_word,
    output logic [2:0]       dac_fullscale_onehot,
    output logic             bias_enable
);
    // ==========================================================
    // registers
    logic [7:0]            dac_control_register;
    logic [7:0]            dac_data_high_byte;
    logic [7:0]            dac_data_low_byte;
    logic                  dac_enable_bit;
    logic [2:0]            dac_update_source;
    logic [1:0]            dac_fullscale_select;
    logic                  strobe_meta_reg;
    logic                  strobe_sync_reg;
    logic                  aw_held_reg;
    logic                  w_held_reg;
    logic [3:0]            awaddr_reg;
    logic [31:0]           wdata_reg;
    logic [3:0]            wstrb_reg;
    logic                  do_write;
    logic                  high_write;
    logic [CDU_DATA_W-1:0] staged_word;
    cdu_fullscale_t        fs_next;

    assign dac_enable_bit       = dac_control_register[CDU_EN_BIT];
    assign dac_update_source    = dac_control_register[CDU_SRC_MSB:CDU_SRC_LSB];
    assign dac_fullscale_select = dac_control_register[CDU_FS_MSB:CDU_FS_LSB];

    // ==========================================================
    // strobe synchroniser
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strobe_meta_reg <= 1'b0;
            strobe_sync_reg <= 1'b0;
        end else begin
            strobe_meta_reg <= external_convert_strobe;
            strobe_sync_reg <= strobe_meta_reg;
        end
    end

    // ==========================================================
    // axi write channel: address and data taken in either order
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    assign do_write      = aw_held_reg & w_held_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            w_held_reg <= 1'b0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= CDU_AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg == CDU_ADDR_CONTROL ||
                             awaddr_reg == CDU_ADDR_DATA_HI ||
                             awaddr_reg == CDU_ADDR_DATA_LO) ? CDU_AXI_OKAY : CDU_AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // only byte lane 0 carries register data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dac_control_register <= CDU_CONTROL_RESET;
        end else if (do_write && wstrb_reg[0] && awaddr_reg == CDU_ADDR_CONTROL) begin
            dac_control_register <= wdata_reg[7:0] & CDU_CONTROL_MASK;
        end
    end

    // staged bytes: never touch the latches directly
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dac_data_high_byte <= '0;
            dac_data_low_byte  <= '0;
        end else if (do_write && wstrb_reg[0]) begin
            if (awaddr_reg == CDU_ADDR_DATA_HI) begin
                dac_data_high_byte <= wdata_reg[7:0];
            end
            if (awaddr_reg == CDU_ADDR_DATA_LO) begin
                dac_data_low_byte <= wdata_reg[7:0] & CDU_LO_MASK;
            end
        end
    end

    assign high_write = do_write && wstrb_reg[0] && awaddr_reg == CDU_ADDR_DATA_HI;
    // high byte first so the word is left-justified
    assign staged_word = {dac_data_high_byte, dac_data_low_byte[7:6]};

    // ==========================================================
    // axi read channel
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= CDU_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= CDU_AXI_OKAY;
            case (s_axi_araddr)
                CDU_ADDR_CONTROL: s_axi_rdata <= {24'h000000, dac_control_register};
                CDU_ADDR_DATA_HI: s_axi_rdata <= {24'h000000, dac_data_high_byte};
                CDU_ADDR_DATA_LO: s_axi_rdata <= {24'h000000, dac_data_low_byte};
                CDU_ADDR_LATCHED: s_axi_rdata <= {22'h0, dac_latch_word};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= CDU_AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // update event selection
    cdu_trig_if trig ();
    assign trig.timer_ovf   = timer_overflow;
    assign trig.strobe_sync = strobe_sync_reg;
    assign trig.high_write  = high_write;
    assign trig.source      = dac_update_source;

    cdu_trig_sel u_sel (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .trig    (trig.sel)
    );

    // the write-mode copy lands one cycle after the high byte is stored,
    // so the latch always sees the new high byte together with the low
    logic fire_d_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fire_d_reg <= 1'b0;
        end else begin
            fire_d_reg <= trig.fire;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dac_latch_word <= '0;
        end else if (fire_d_reg) begin
            dac_latch_word <= staged_word;
        end
    end

    // ==========================================================
    // full scale and pin muxing
    always_comb begin
        case (dac_fullscale_select)
            2'h0:    fs_next = CDU_FS_HALF_MA;
            2'h1:    fs_next = CDU_FS_ONE_MA;
            default: fs_next = CDU_FS_TWO_MA;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dac_fullscale_onehot <= CDU_FS_TWO_MA;
        end else begin
            dac_fullscale_onehot <= fs_next;
        end
    end

    assign pin_out            = dac_enable_bit ? 1'b0 : gpio_out;
    assign pin_oe             = gpio_oe & ~dac_enable_bit;
    assign pin_pullup_on      = gpio_pullup_en & ~dac_enable_bit;
    assign pin_analog_connect = dac_enable_bit;
    assign bias_enable        = dac_enable_bit;
endmodule // cdu_top

// ===== hw/cdu_pkg.sv
// Purpose: constants and types for the current dac update control block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes:   data word is left-justified across the high and low bytes
package cdu_pkg;
    // register byte addresses
    localparam logic [3:0] CDU_ADDR_CONTROL  = 4'h0;
    localparam logic [3:0] CDU_ADDR_DATA_HI  = 4'h4;
    localparam logic [3:0] CDU_ADDR_DATA_LO  = 4'h8;
    localparam logic [3:0] CDU_ADDR_LATCHED  = 4'hc;
    // control register fields
    localparam int CDU_EN_BIT     = 7;
    localparam int CDU_SRC_MSB    = 6;
    localparam int CDU_SRC_LSB    = 4;
    localparam int CDU_FS_MSB     = 1;
    localparam int CDU_FS_LSB     = 0;
    localparam logic [7:0] CDU_CONTROL_RESET = 8'h72;
    localparam logic [7:0] CDU_LO_MASK       = 8'hc0;
    // bits 3:2 of the control register are unused and read back as zero
    localparam logic [7:0] CDU_CONTROL_MASK  = 8'hf3;
    localparam int CDU_DATA_W     = 10;
    // update source codes
    localparam logic [2:0] CDU_SRC_T0   = 3'h0;
    localparam logic [2:0] CDU_SRC_T1   = 3'h1;
    localparam logic [2:0] CDU_SRC_T2   = 3'h2;
    localparam logic [2:0] CDU_SRC_T3   = 3'h3;
    localparam logic [2:0] CDU_SRC_RISE = 3'h4;
    localparam logic [2:0] CDU_SRC_FALL = 3'h5;
    localparam logic [2:0] CDU_SRC_ANY  = 3'h6;
    localparam logic [2:0] CDU_SRC_WRH  = 3'h7;
    // full-scale select, one-hot output
    typedef enum logic [2:0] {
        CDU_FS_HALF_MA = 3'h1,
        CDU_FS_ONE_MA  = 3'h2,
        CDU_FS_TWO_MA  = 3'h4
    } cdu_fullscale_t;
    localparam logic [1:0] CDU_AXI_OKAY   = 2'h0;
    localparam logic [1:0] CDU_AXI_SLVERR = 2'h2;
endpackage

// ===== hw/cdu_trig_if.sv
// Purpose: carries the trigger-source signals between top and selector
// Assumes: all signals on sys_clk
// Notes:   strobe already synchronised before entering here
`timescale 1ns/10ps
interface cdu_trig_if;
    logic [3:0] timer_ovf;
    logic       strobe_sync;
    logic       high_write;
    logic [2:0] source;
    logic       fire;
    modport top (output timer_ovf, output strobe_sync, output high_write,
                 output source, input fire);
    modport sel (input timer_ovf, input strobe_sync, input high_write,
                 input source, output fire);
endinterface

// ===== hw/cdu_trig_sel.sv
// Purpose: picks the update event from the selected source
// Assumes: timer overflow inputs are one-cycle pulses on sys_clk
// Notes:   edge detect uses the synchronised strobe only
`timescale 1ns/10ps
module cdu_trig_sel
    import cdu_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // trigger sources
    cdu_trig_if.sel   trig
);
    logic strobe_prev_reg;
    logic rise;
    logic fall;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strobe_prev_reg <= 1'b0;
        end else begin
            strobe_prev_reg <= trig.strobe_sync;
        end
    end

    assign rise = trig.strobe_sync & ~strobe_prev_reg;
    assign fall = ~trig.strobe_sync & strobe_prev_reg;

    always_comb begin
        case (trig.source)
            CDU_SRC_T0:   trig.fire = trig.timer_ovf[0];
            CDU_SRC_T1:   trig.fire = trig.timer_ovf[1];
            CDU_SRC_T2:   trig.fire = trig.timer_ovf[2];
            CDU_SRC_T3:   trig.fire = trig.timer_ovf[3];
            CDU_SRC_RISE: trig.fire = rise;
            CDU_SRC_FALL: trig.fire = fall;
            CDU_SRC_ANY:  trig.fire = rise | fall;
            CDU_SRC_WRH:  trig.fire = trig.high_write;
            default:      trig.fire = 1'b0;
        endcase
    end
endmodule // cdu_trig_sel

// ===== verification/cdu_top_props.sv
// Purpose: port checker for cdu_top
// Assumes: write address and data offered together
// Notes:   mirrors source and staged word from bus writes
`timescale 1ns/10ps
module cdu_checker
    import cdu_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // bus writes
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    // events and pins
    input wire logic [3:0]  timer_overflow,
    input wire logic        external_convert_strobe,
    input wire logic        gpio_out,
    input wire logic        gpio_oe,
    input wire logic        gpio_pullup_en,
    input wire logic        pin_out,
    input wire logic        pin_oe,
    input wire logic        pin_pullup_on,
    input wire logic        pin_analog_connect,
    input wire logic        bias_enable,
    input wire logic [9:0]  dac_latch_word,
    input wire logic [2:0]  dac_fullscale_onehot
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // mirror
    logic [2:0] src;
    logic [9:0] stg;
    logic [7:0] hist;
    logic       strobe_q;
    logic       wr_hs;
    logic       ev;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // recent legal causes; a latch change without one is spurious
    assign ev = (wr_hs && s_axi_awaddr == CDU_ADDR_DATA_HI) || (|timer_overflow)
        || (external_convert_strobe != strobe_q);
    always_ff @(posedge sys_clk) begin
        strobe_q <= external_convert_strobe;
        hist <= sys_rst ? 8'h00 : {hist[6:0], ev};
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            src <= CDU_SRC_WRH;
            stg <= 10'h000;
        end else if (wr_hs && s_axi_awaddr == CDU_ADDR_CONTROL) begin
            src <= s_axi_wdata[6:4];
        end else if (wr_hs && s_axi_awaddr == CDU_ADDR_DATA_HI) begin
            stg[9:2] <= s_axi_wdata[7:0];
        end else if (wr_hs && s_axi_awaddr == CDU_ADDR_DATA_LO) begin
            stg[1:0] <= s_axi_wdata[7:6];
        end
    end
    sequence hi_write_s;
        wr_hs && s_axi_awaddr == CDU_ADDR_DATA_HI;
    endsequence
    sequence strobe_edge_s;
        (src == CDU_SRC_RISE && $rose(external_convert_strobe))
        || (src == CDU_SRC_FALL && $fell(external_convert_strobe))
        || (src == CDU_SRC_ANY && $changed(external_convert_strobe));
    endsequence
    // ==========================================
    // assertions
    pin_pass_a: assert property (!pin_analog_connect |-> pin_out == gpio_out
        && pin_oe == gpio_oe && pin_pullup_on == gpio_pullup_en)
        else $error("pin not passed to port logic");
    pin_block_a: assert property (pin_analog_connect |-> !pin_oe && !pin_pullup_on)
        else $error("pin driver on while converter enabled");
    bias_follow_a: assert property (bias_enable == pin_analog_connect)
        else $error("bias not tied to enable");
    fs_onehot_a: assert property ($onehot(dac_fullscale_onehot))
        else $error("full-scale select not one of three");
    fs_reset_a: assert property (disable iff (1'b0) sys_rst |=>
        dac_fullscale_onehot == 3'h4 && dac_latch_word == 10'h000)
        else $error("reset state wrong");
    wr_update_a: assert property (hi_write_s ##0 src == CDU_SRC_WRH
        |-> ##[1:4] dac_latch_word == stg) else $error("high write did not update");
    timer_update_a: assert property (src < 3'h4 && timer_overflow[src[1:0]]
        |-> ##[1:3] dac_latch_word == stg) else $error("timer did not update");
    strobe_update_a: assert property (strobe_edge_s |-> ##[2:7] dac_latch_word == stg)
        else $error("strobe edge did not update");
    hold_data_a: assert property ($changed(dac_latch_word) |-> |hist)
        else $error("latch changed without event");
endmodule // cdu_checker

bind cdu_top cdu_checker chk_u (.*);

// ===== verification/cdu_cpu_model.sv
// Purpose: cpu side register master for cdu_top
// Assumes: ready sampled half a cycle before the taking edge
// Notes:   released write data is inverted, never left showing
`timescale 1ns/10ps
module cdu_cpu_model (
    // clock
    input wire logic        sys_clk,
    // write
    output logic [3:0]      s_axi_awaddr,
    output logic            s_axi_awvalid,
    input wire logic        s_axi_awready,
    output logic [31:0]     s_axi_wdata,
    output logic [3:0]      s_axi_wstrb,
    output logic            s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    output logic            s_axi_bready,
    // read
    output logic [3:0]      s_axi_araddr,
    output logic            s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    output logic            s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ga = 1'b0;
        logic gw = 1'b0;
        logic ta;
        logic tw;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ga && gw)) begin
            @(negedge sys_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge sys_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tw) s_axi_wdata <= ~d;
            ga = ga || ta;
            gw = gw || tw;
        end
        do begin
            @(negedge sys_clk);
            ta = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge sys_clk);
        end while (!ta);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        logic t;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge sys_clk);
            t = s_axi_arready;
            @(posedge sys_clk);
        end while (!t);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge sys_clk);
            t = s_axi_rvalid;
            d = s_axi_rdata;
            @(posedge sys_clk);
        end while (!t);
        s_axi_rready <= 1'b0;
    endtask
endmodule // cdu_cpu_model

// ===== verification/test_current_dac_update_control.sv
// Purpose: self-checking bench for cdu_top
// Assumes: cpu model tasks speak the register bus
// Notes:   outputs sampled at the falling edge
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
    $display("BAD %0t %h %h", $time, (a), (e)); end end
module test_current_dac_update_control
    import cdu_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [3:0]  timer_overflow = 4'h0;
    logic        external_convert_strobe = 1'b0;
    logic        gpio_out = 1'b0, gpio_oe = 1'b0, gpio_pullup_en = 1'b0;
    logic        pin_out, pin_oe, pin_pullup_on, pin_analog_connect, bias_enable;
    logic [9:0]  dac_latch_word, expect_word;
    logic [2:0]  dac_fullscale_onehot;
    logic [7:0]  hv;
    int          fails = 0, checks_done = 0, cyc = 0;
    cdu_top dut_u (.*);
    cdu_cpu_model cpu_u (.*);
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        {gpio_pullup_en, gpio_oe, gpio_out} <= cyc[2:0];
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic put(input logic [3:0] a, input logic [31:0] d);
        cpu_u.wr(a, d, resp);
        `CHK(resp, CDU_AXI_OKAY)
    endtask
    task automatic check_latch(input logic [9:0] e);
        wait_n(0);
        `CHK(dac_latch_word, e)
        cpu_u.rd(CDU_ADDR_LATCHED, rdat);
        `CHK(rdat, {22'h0, e})
    endtask
    task automatic pulse_timer(input int t);
        @(posedge sys_clk);
        timer_overflow <= 4'h1 << t;
        @(posedge sys_clk);
        timer_overflow <= 4'h0;
        wait_n(3);
    endtask
    task automatic strobe_to(input logic v);
        @(posedge sys_clk);
        external_convert_strobe <= v;
        wait_n(8);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_n(0);
        `CHK(dac_fullscale_onehot, 3'h4)
        cpu_u.rd(CDU_ADDR_CONTROL, rdat);
        `CHK(rdat, {24'h0, CDU_CONTROL_RESET})
        `CHK(s_axi_rresp, CDU_AXI_OKAY)
        `CHK({pin_analog_connect, bias_enable}, 2'h0)
        put(CDU_ADDR_CONTROL, 32'hf2);
        wait_n(1);
        `CHK({pin_oe, pin_pullup_on, pin_analog_connect, bias_enable}, 4'h3)
        put(CDU_ADDR_DATA_LO, 32'hff);
        check_latch(10'h000);
        cpu_u.rd(CDU_ADDR_DATA_LO, rdat);
        `CHK(rdat, 32'hc0)
        put(CDU_ADDR_DATA_HI, 32'ha5);
        wait_n(3);
        check_latch(10'h297);
        put(CDU_ADDR_DATA_LO, 32'h00);
        put(CDU_ADDR_DATA_HI, 32'h12);
        wait_n(3);
        check_latch(10'h048);
        cpu_u.wr(CDU_ADDR_LATCHED, 32'h3ff, resp);
        `CHK(resp, CDU_AXI_SLVERR)
        check_latch(10'h048);
        cpu_u.rd(4'h1, rdat);
        `CHK({rdat, s_axi_rresp}, {32'h0, CDU_AXI_SLVERR})
        for (int f = 0; f < 4; f++) begin
            put(CDU_ADDR_CONTROL, {24'h0, 6'h3c, f[1:0]});
            wait_n(2);
            `CHK(dac_fullscale_onehot, f == 0 ? 3'h1 : f == 1 ? 3'h2 : 3'h4)
        end
        expect_word = 10'h048;
        for (int t = 0; t < 4; t++) begin
            put(CDU_ADDR_CONTROL, {24'h0, 2'h2, t[1:0], 4'h2});
            hv = 8'h30 | {6'h0, t[1:0]};
            put(CDU_ADDR_DATA_LO, 32'h40);
            put(CDU_ADDR_DATA_HI, {24'h0, hv});
            pulse_timer((t + 1) % 4);
            check_latch(expect_word);
            expect_word = {hv, 2'b01};
            pulse_timer(t);
            check_latch(expect_word);
            pulse_timer(t);
            check_latch(expect_word);
        end
        for (int s = 4; s < 7; s++) begin
            put(CDU_ADDR_CONTROL, {24'h0, 1'b1, s[2:0], 4'h2});
            hv = hv + 8'h11;
            put(CDU_ADDR_DATA_HI, {24'h0, hv});
            strobe_to(1'b1);
            check_latch(s == 5 ? expect_word : {hv, 2'b01});
            strobe_to(1'b0);
            expect_word = {hv, 2'b01};
            check_latch(expect_word);
        end
        print_verdict();
    end
endmodule // test_current_dac_update_control
